// ---- lfi_line_feed.sv ----
`timescale 1ns/100ps

// small synchronous fifo with valid/ready on both sides
module lfi_fifo
    import lfi_pkg::*;
#(
    parameter int W = 7,
    parameter int D = 8
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    // filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_ff [D];   // storage words
    logic [AW:0]  wr_ff;        // write pointer with wrap bit
    logic [AW:0]  rd_ff;        // read pointer with wrap bit
    logic         push;         // word accepted
    logic         pop;          // word taken

    // full when pointers differ only in wrap bit
    assign in_ready  = (wr_ff != {~rd_ff[AW], rd_ff[AW-1:0]});
    assign out_valid = (wr_ff != rd_ff);
    assign out_data  = mem_ff[rd_ff[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer update
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            if (push) wr_ff <= wr_ff + 1'b1;
            if (pop) rd_ff <= rd_ff + 1'b1;
        end
    end

    // storage write, no reset needed
    always_ff @(posedge core_clk) begin
        if (push) mem_ff[wr_ff[AW-1:0]] <= in_data;
    end
endmodule

// carriage return to line feed inserter, both directions
module lfi_line_feed
    import lfi_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // keyboard side
    input  wire logic [6:0] kbd_char,
    input  wire logic       kbd_strobe,
    output logic            kbd_ready,
    // front panel and jumper
    input  wire logic       crlf_expand_switch,
    input  wire logic       rx_insert_jumper,
    // toward the uart transmitter
    input  wire logic       tx_accept_ready_n,
    output lfi_tx_s         tx_out,
    output logic            inserted_strobe_out,
    output logic            kbd_cr_detect_n,
    // shared receive bus
    input  wire logic [6:0] rx_bus_in,
    output logic [6:0]      rx_bus_out,
    output logic            rx_bus_oe,
    // receive handshakes
    input  wire logic       rx_char_avail_n,
    input  wire logic       clear_char_avail_n,
    output logic            receiver_output_enable,
    output logic            option_char_avail_n,
    output logic            rx_cr_detect_n
);
    // synchroniser stages and edge history
    lfi_pins_s  pin_raw;        // raw pin bundle
    lfi_pins_s  sync1_ff;       // first stage, read by second only
    lfi_pins_s  sync2_ff;       // settled pins
    lfi_pins_s  last_ff;        // previous settled pins
    // transmit path
    lfi_tx_e    tx_ff;          // transmit control
    lfi_tx_e    nxt_tx;
    lfi_tx_s    txo_ff;         // registered uart outputs
    lfi_tx_s    nxt_txo;
    logic       stb_rise;       // keystrobe leading edge
    logic       rdy;            // uart ready, high true
    logic       fifo_valid;     // buffered key waiting
    logic       fifo_pop;       // key handed to uart
    logic [6:0] fifo_char;      // oldest buffered key
    logic       pop_is_cr;      // key is carriage return
    // receive path
    lfi_rx_e    rx_ff;          // receive control
    lfi_rx_e    nxt_rx;
    logic       clr_lead;       // clear leading edge
    logic       clr_trail;      // clear trailing edge
    logic       rx_cr_hit;      // qualified carriage return
    logic       rx_lf_on;       // receive line feed active

    // gather pins into one bundle
    assign pin_raw = '{kbd_char: kbd_char, kbd_strobe: kbd_strobe,
                       expand_sw: crlf_expand_switch,
                       ready_n: tx_accept_ready_n, rx_char: rx_bus_in,
                       avail_n: rx_char_avail_n,
                       clear_n: clear_char_avail_n,
                       jumper: rx_insert_jumper};

    // two-flop synchroniser plus history for edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= '{ready_n: 1'b1, avail_n: 1'b1,
                          clear_n: 1'b1, default: '0};
            sync2_ff <= '{ready_n: 1'b1, avail_n: 1'b1,
                          clear_n: 1'b1, default: '0};
            last_ff  <= '{ready_n: 1'b1, avail_n: 1'b1,
                          clear_n: 1'b1, default: '0};
        end else begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
            last_ff  <= sync2_ff;
        end
    end

    // edge and level decode on settled pins
    assign stb_rise  = sync2_ff.kbd_strobe && !last_ff.kbd_strobe;
    assign rdy       = !sync2_ff.ready_n;
    assign clr_lead  = !sync2_ff.clear_n && last_ff.clear_n;
    assign clr_trail = sync2_ff.clear_n && !last_ff.clear_n;

    // keyboard buffer, keyboard sees back-pressure via kbd_ready
    lfi_fifo #(
        .W (FIFO_W),
        .D (FIFO_DEPTH)
    ) u_kbd_fifo (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (stb_rise),
        .in_ready  (kbd_ready),
        .in_data   (sync2_ff.kbd_char),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_char)
    );

    // take a key only when idle and uart ready
    assign fifo_pop  = (tx_ff == TX_IDLE) && fifo_valid && rdy;
    assign pop_is_cr = (fifo_char == CODE_CR);

    // transmit control next state and outputs
    always_comb begin
        nxt_tx  = tx_ff;
        nxt_txo = '{code: txo_ff.code, strobe: 1'b0};
        case (tx_ff)
            TX_IDLE: begin
                if (fifo_pop) begin
                    // relay key unchanged with a one-cycle strobe
                    nxt_txo = '{code: fifo_char, strobe: 1'b1};
                    if (pop_is_cr && sync2_ff.expand_sw) begin
                        nxt_tx = TX_CRBUSY;
                    end else begin
                        nxt_tx = TX_CHBUSY;
                    end
                end
            end
            TX_CHBUSY: begin
                // wait for uart to go busy
                if (!rdy) nxt_tx = TX_IDLE;
            end
            TX_CRBUSY: begin
                // uart holds ready_n high while busy
                if (!rdy) nxt_tx = TX_CRWAIT;
            end
            TX_CRWAIT: begin
                if (rdy) begin
                    // accepted: line feed with one strobe
                    nxt_tx  = TX_LFBUSY;
                    nxt_txo = '{code: CODE_LF, strobe: 1'b1};
                end
            end
            TX_LFBUSY: begin
                nxt_txo.code = CODE_LF;
                if (!rdy) nxt_tx = TX_LFDONE;
            end
            TX_LFDONE: begin
                nxt_txo.code = CODE_LF;
                // line feed taken, back to relay
                if (rdy) nxt_tx = TX_IDLE;
            end
            default: nxt_tx = TX_IDLE;
        endcase
    end

    // transmit registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ff  <= TX_IDLE;
            txo_ff <= '0;
        end else begin
            tx_ff  <= nxt_tx;
            txo_ff <= nxt_txo;
        end
    end

    // transmit outputs; detect stage cleared on line feed entry
    assign tx_out              = txo_ff;
    assign inserted_strobe_out = txo_ff.strobe;
    assign kbd_cr_detect_n     = !(tx_ff == TX_CRBUSY ||
                                   tx_ff == TX_CRWAIT);

    // qualified receive carriage return
    assign rx_cr_hit = !sync2_ff.avail_n && sync2_ff.jumper &&
                       (sync2_ff.rx_char == CODE_CR);

    // receive control next state
    always_comb begin
        nxt_rx = rx_ff;
        case (rx_ff)
            RX_MON: begin
                if (rx_cr_hit) nxt_rx = RX_CRSEEN;
            end
            RX_CRSEEN: begin
                if (clr_lead) nxt_rx = RX_LFCLR;
            end
            RX_LFCLR: begin
                if (clr_trail) nxt_rx = RX_LFWAIT;
            end
            RX_LFWAIT: begin
                if (clr_lead) nxt_rx = RX_MON;
            end
            default: nxt_rx = RX_MON;
        endcase
    end

    // receive register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_ff <= RX_MON;
        end else begin
            rx_ff <= nxt_rx;
        end
    end

    // receive outputs other than rx_cr_detect_n and the constant rx_bus_out follow line feed activity
    assign rx_lf_on               = (rx_ff == RX_LFCLR) ||
                                    (rx_ff == RX_LFWAIT);
    assign receiver_output_enable = !rx_lf_on;
    assign rx_bus_oe              = rx_lf_on;
    assign rx_bus_out             = CODE_LF;
    assign option_char_avail_n    = !rx_lf_on;
    assign rx_cr_detect_n         = !(rx_ff == RX_CRSEEN ||
                                      rx_ff == RX_LFCLR);

    // checks on the design's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_cr_taken;
        fifo_pop && pop_is_cr && sync2_ff.expand_sw;
    endsequence

    sequence s_cr_accepted;
        (tx_ff == TX_CRWAIT) && rdy;
    endsequence

    sequence s_first_clear;
        (rx_ff == RX_CRSEEN) && clr_lead;
    endsequence

    chk_relay_plain: assert property (
        fifo_pop && !sync2_ff.expand_sw |=> tx_ff == TX_CHBUSY)
        else $error("plain relay did not skip insertion");

    chk_strobe_char: assert property (
        fifo_pop |=> inserted_strobe_out && tx_out.code == $past(fifo_char))
        else $error("relayed key or strobe wrong");

    chk_cr_detect: assert property (
        s_cr_taken |=> !kbd_cr_detect_n && tx_out.code == CODE_CR)
        else $error("carriage return not flagged or not sent");

    chk_lf_entry: assert property (
        s_cr_accepted |=> inserted_strobe_out && kbd_cr_detect_n
                          ##1 !inserted_strobe_out)
        else $error("line feed strobe or detect clear wrong");

    chk_lf_drive: assert property (
        tx_ff == TX_LFBUSY || tx_ff == TX_LFDONE |-> tx_out.code == CODE_LF
                                                     && !fifo_pop)
        else $error("keyboard data leaked during line feed");

    chk_lf_exit: assert property (
        (tx_ff == TX_LFDONE) && rdy |=> tx_ff == TX_IDLE)
        else $error("line feed state not cleared by ready");

    chk_rx_set: assert property (
        (rx_ff == RX_MON) && rx_cr_hit |=> !rx_cr_detect_n)
        else $error("received carriage return not caught");

    chk_rx_lf_out: assert property (
        rx_lf_on |-> !receiver_output_enable && rx_bus_oe
                     && !option_char_avail_n && rx_bus_out == CODE_LF)
        else $error("receive line feed outputs wrong");

    chk_rx_done: assert property (
        (rx_ff == RX_LFWAIT) && clr_lead |=> receiver_output_enable
                                             && option_char_avail_n)
        else $error("second clear did not end line feed");

    chk_ready_start: assert property (
        (tx_ff == TX_CRBUSY) && !rdy |=> tx_ff == TX_CRWAIT)
        else $error("busy uart did not arm insertion");

    chk_no_extra: assert property (
        (tx_ff == TX_CRWAIT) || (tx_ff == TX_LFDONE)
            |-> !inserted_strobe_out)
        else $error("extra strobe while waiting on uart");

    chk_lf_wait: assert property (
        (tx_ff == TX_LFBUSY) && !rdy |=> tx_ff == TX_LFDONE)
        else $error("line feed busy phase not tracked");

    chk_plain_quiet: assert property (
        (tx_ff == TX_CHBUSY) |-> kbd_cr_detect_n && !fifo_pop)
        else $error("plain relay took extra action");

    chk_lf_first: assert property (
        s_first_clear |=> rx_lf_on && !rx_cr_detect_n)
        else $error("first clear did not start line feed");

    chk_rx_trail: assert property (
        (rx_ff == RX_LFCLR) && clr_trail |=> rx_cr_detect_n && rx_lf_on)
        else $error("trailing clear did not reset detect");

    chk_rx_hold: assert property (
        (rx_ff == RX_LFWAIT) && !clr_lead |=> rx_lf_on
                                              && rx_bus_out == CODE_LF)
        else $error("line feed dropped before second clear");

    chk_rx_nojump: assert property (
        !sync2_ff.jumper && (rx_ff == RX_MON) |=> rx_ff == RX_MON)
        else $error("insertion started without jumper");

    chk_rx_idle: assert property (
        (rx_ff == RX_MON) || (rx_ff == RX_CRSEEN)
            |-> option_char_avail_n && receiver_output_enable && !rx_bus_oe)
        else $error("option drove bus or avail while idle");
endmodule

// ---- lfi_pkg.sv ----
// Behaviour
// - switch off relays keyboard characters unchanged
// - keystrobe forwarded with each relayed character
// - carriage return with switch on flags detect
// - carriage return still sent, line feed follows
// - ready falling after carriage return starts insertion
// - insertion drives line feed, blocks keyboard data
// - one strobe for line feed, detect cleared
// - next ready low ends insertion, resumes relay
// - receive side watches the shared character bus
// - received carriage return sets control if jumpered
// - first clear leading edge starts line feed
// - first clear trailing edge resets detect stage
// - receiver output disabled during line feed
// - line feed driven onto shared bus
// - option data-available held low during line feed
// - second clear ends line feed, restores receiver
// - no jumper disables receive insertion only
// - option data-available high until line feed ready
package lfi_pkg;

    localparam int        CHAR_W     = 7;      // seven-bit characters
    localparam logic [6:0] CODE_CR   = 7'h0d;
    localparam logic [6:0] CODE_LF   = 7'h0a;
    localparam int        FIFO_W     = 7;      // keyboard buffer width
    localparam int        FIFO_DEPTH = 8;      // keyboard buffer depth

    // transmit control, one-hot
    typedef enum logic [5:0] {
        TX_IDLE   = 6'h01,  // waiting for a character and ready
        TX_CHBUSY = 6'h02,  // plain character handed over
        TX_CRBUSY = 6'h04,  // carriage return handed over
        TX_CRWAIT = 6'h08,  // uart busy with carriage return
        TX_LFBUSY = 6'h10,  // line feed handed over
        TX_LFDONE = 6'h20   // uart busy with line feed
    } lfi_tx_e;

    // receive control, one-hot
    typedef enum logic [3:0] {
        RX_MON    = 4'h1,   // watching the bus
        RX_CRSEEN = 4'h2,   // carriage return caught
        RX_LFCLR  = 4'h4,   // line feed on, first clear still low
        RX_LFWAIT = 4'h8    // line feed on, waiting second clear
    } lfi_rx_e;

    // pins crossing into the clock domain
    typedef struct packed {
        logic [6:0] kbd_char;   // keyboard character
        logic       kbd_strobe; // keystrobe, high active
        logic       expand_sw;  // line feed expansion switch
        logic       ready_n;    // uart transmit ready, low active
        logic [6:0] rx_char;    // shared receive bus
        logic       avail_n;    // uart data available, low active
        logic       clear_n;    // clear data available, low active
        logic       jumper;     // receive insertion jumper
    } lfi_pins_s;

    // character and strobe toward the uart
    typedef struct packed {
        logic [6:0] code;       // outgoing character
        logic       strobe;     // one-cycle keystrobe
    } lfi_tx_s;

endpackage

// ---- lfi_uart_model.sv ----
`timescale 1ns/100ps

// far-side transmitter: goes busy after each strobe, then ready again
module lfi_uart_model
    import lfi_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    // from the inserter
    input  wire logic       strobe,
    input  wire logic [6:0] code,
    // test controls
    input  wire logic       stall,
    input  wire logic       slow,
    // back to the inserter
    output logic            ready_n
);
    logic [5:0] busy_ff;        // cycles left busy
    logic [6:0] log_q [0:31];   // last 32 characters taken
    int         log_cnt;        // characters taken so far

    // take a character, stay busy, then report ready unless stalled
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_ff <= 6'h00;
            ready_n <= 1'b0;
            log_cnt <= 0;
        end else if (strobe) begin
            log_q[log_cnt[4:0]] <= code;
            log_cnt             <= log_cnt + 1;
            ready_n             <= 1'b1;
            busy_ff             <= slow ? 6'h1e : 6'h04;
        end else if (busy_ff != 6'h00) begin
            busy_ff <= busy_ff - 6'h01;
        end else begin
            ready_n <= stall;
        end
    end
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps

// self-checking bench for the line feed inserter
module testbench
    import lfi_pkg::*;
;
    logic       core_clk = 1'b0;  // 100 mhz
    logic       rst_n, kbd_strobe, kbd_ready, sw, jmp, ready_n;
    logic       stall, slow, ins_strobe, kbd_det_n, rx_oe, rx_en;
    logic       avail_n, clear_n, opt_n, rx_det_n;
    logic [6:0] kbd_char, rx_in, rx_out, uart_char;
    logic [6:0] idle_pat = 7'h00; // released bus wanders
    lfi_tx_s    tx_out;
    int         error_cnt = 0;
    int         tests_run = 0;

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) idle_pat <= idle_pat + 7'h13;

    // shared bus: inserter, else receiver, else nobody
    assign rx_in = rx_oe ? rx_out : (rx_en ? uart_char : idle_pat);

    lfi_line_feed i_dut (
        .core_clk(core_clk), .rst_n(rst_n), .kbd_char(kbd_char),
        .kbd_strobe(kbd_strobe), .kbd_ready(kbd_ready),
        .crlf_expand_switch(sw), .rx_insert_jumper(jmp),
        .tx_accept_ready_n(ready_n), .tx_out(tx_out),
        .inserted_strobe_out(ins_strobe), .kbd_cr_detect_n(kbd_det_n),
        .rx_bus_in(rx_in), .rx_bus_out(rx_out), .rx_bus_oe(rx_oe),
        .rx_char_avail_n(avail_n), .clear_char_avail_n(clear_n),
        .receiver_output_enable(rx_en), .option_char_avail_n(opt_n),
        .rx_cr_detect_n(rx_det_n));

    lfi_uart_model i_uart (
        .core_clk(core_clk), .rst_n(rst_n), .strobe(ins_strobe),
        .code(tx_out.code), .stall(stall), .slow(slow),
        .ready_n(ready_n));

    // compare and count
    task automatic chk(input logic [6:0] got, input logic [6:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one keystroke, strobe held, then a gap
    task automatic key(input logic [6:0] c);
        @(posedge core_clk);
        kbd_char   <= c;
        kbd_strobe <= 1'b1;
        repeat (4) @(posedge core_clk);
        kbd_strobe <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask

    // bounded wait for the transmitter log to reach n
    task automatic wait_cnt(input int n);
        for (int i = 0; i < 2000 && i_uart.log_cnt < n; i++)
            @(posedge core_clk);
        #1;
    endtask

    // switch off: carriage return passes plain
    task automatic t_tx_relay();
        int b;
        b = i_uart.log_cnt;
        key(CODE_CR);
        key(7'h41);
        wait_cnt(b + 2);
        repeat (60) @(posedge core_clk);
        #1;
        chk(7'(i_uart.log_cnt), 7'(b + 2));
        chk(i_uart.log_q[b], CODE_CR);
        chk(i_uart.log_q[b + 1], 7'h41);
        chk(kbd_det_n, 1'b1);
    endtask

    // switch on, slow uart, next key typed while busy
    task automatic t_tx_insert();
        int b;
        @(posedge core_clk);
        sw   <= 1'b1;
        slow <= 1'b1;
        b = i_uart.log_cnt;
        key(CODE_CR);
        wait_cnt(b + 1);
        chk(kbd_det_n, 1'b0);
        key(7'h42);
        wait_cnt(b + 2);
        chk(kbd_det_n, 1'b1);
        chk(i_uart.log_q[b], CODE_CR);
        chk(i_uart.log_q[b + 1], CODE_LF);
        wait_cnt(b + 3);
        chk(i_uart.log_q[b + 2], 7'h42);
        repeat (120) @(posedge core_clk);
        #1;
        chk(7'(i_uart.log_cnt), 7'(b + 3));
        @(posedge core_clk);
        sw   <= 1'b0;
        slow <= 1'b0;
    endtask

    // stalled uart: buffer fills and refuses, then drains in order
    task automatic t_fifo_full();
        int b;
        @(posedge core_clk);
        stall <= 1'b1;
        b = i_uart.log_cnt;
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < 9; i++)
            key(7'h30 + 7'(i));
        #1;
        chk(kbd_ready, 1'b0);
        chk(7'(i_uart.log_cnt), 7'(b));
        @(posedge core_clk);
        stall <= 1'b0;
        wait_cnt(b + 8);
        repeat (100) @(posedge core_clk);
        #1;
        chk(7'(i_uart.log_cnt), 7'(b + 8));
        for (int i = 0; i < 8; i++)
            chk(i_uart.log_q[b + i], 7'h30 + 7'(i));
    endtask

    // received character, two clear pulses, watch the bus
    task automatic rx_run(input logic [6:0] c, input logic j,
                          input logic ins);
        @(posedge core_clk);
        jmp       <= j;
        uart_char <= c;
        avail_n   <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        chk(rx_det_n, !ins);
        chk(opt_n, 1'b1);
        @(posedge core_clk);
        avail_n <= 1'b1;
        clear_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        chk(rx_oe, ins);
        chk(rx_en, !ins);
        chk(opt_n, !ins);
        chk(rx_in, ins ? CODE_LF : c);
        chk(rx_det_n, !ins);
        @(posedge core_clk);
        clear_n <= 1'b1;
        repeat (5) @(posedge core_clk);
        #1;
        chk(rx_det_n, 1'b1);
        chk(rx_oe, ins);
        @(posedge core_clk);
        clear_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        chk(rx_oe, 1'b0);
        chk(rx_en, 1'b1);
        chk(opt_n, 1'b1);
        @(posedge core_clk);
        clear_n <= 1'b1;
        repeat (5) @(posedge core_clk);
    endtask

    // jumper fitted: carriage return gets a line feed, others not
    task automatic t_rx_insert();
        rx_run(CODE_CR, 1'b1, 1'b1);
        rx_run(7'h41, 1'b1, 1'b0);
    endtask

    // jumper out: no receive insertion
    task automatic t_rx_nojumper();
        rx_run(CODE_CR, 1'b0, 1'b0);
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        rst_n = 1'b0;
        kbd_char = 7'h00;
        kbd_strobe = 1'b0;
        sw = 1'b0;
        jmp = 1'b0;
        stall = 1'b0;
        slow = 1'b0;
        avail_n = 1'b1;
        clear_n = 1'b1;
        uart_char = 7'h00;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_tx_relay();
        t_tx_insert();
        t_fifo_full();
        t_rx_insert();
        t_rx_nojumper();
        conclude();
    end

    // hang guard at 20000 cycles, well past the expected few hundred cycles
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end
endmodule
